// ---- core/ddsl_loader.sv ----
/*
  Serial front end of a dual current-output converter: shift register,
  word FIFO, input and converter register ranks, clear to preset.
  Assumes all pins are asynchronous to core_clk and that the serial clock
  is slow enough (period well over four core cycles) to be edge-sampled.
*/
`timescale 1ns/1ps

// ============================================================
// Word FIFO
module ddsl_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ============================================================
// Loader top
// Function
// [RQ1] Host presents serial bits while select low; device shifts on serial clock rise.
// [RQ2] Wide word is 18 bits MSB first: two address bits, sixteen data bits.
// [RQ3] Wide variant keeps only the last 18 bits shifted before select rises.
// [RQ4] Narrow variant uses 16-bit word, address then 14 data, last 16 kept.
// [RQ5] Select rising edge loads data field into addressed input registers.
// [RQ6] Address 00 none, 01 channel A, 10 channel B, 11 both.
// [RQ7] Shift only on serial clock rise with select low; otherwise unchanged.
// [RQ8] Host keeps serial clock low and still while raising select.
// [RQ9] Select rise with serial clock low updates input register from shift register.
// [RQ10] Load strobe low makes converter registers follow input registers.
// [RQ11] With strobe high, input loads leave converter registers unchanged.
// [RQ12] Host writes A, then B, then pulses strobe for joint update.
// [RQ13] Clear low forces both ranks to zero or midscale per preset select.
// [RQ14] Byte hosts send three bytes; upper six bits are dropped.
// [RQ15] Narrow variant midscale preset is 0x2000.
// [RQ16] Load strobe is level sensitive active low, moving all input registers.
// [RQ17] After power-on both register ranks hold zero.
// [RQ18] Clear wins over any concurrent select load or strobe transfer.
module ddsl_loader (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic chip_sel_n,
  input wire logic load_strobe_n,
  input wire logic clear_to_preset_n,
  input wire logic preset_mid,
  output ddsl_pkg::ddsl_pair_t input_regs,
  output ddsl_pkg::ddsl_pair_t conv_regs,
  output logic word_dropped
);
  import ddsl_pkg::*;

  // ==========================================================
  // Pin synchronisers
  localparam int NPIN = 6;
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;
  logic sclk_prev_ff;
  logic cs_prev_ff;
  logic sclk_s, sdi_s, cs_n_s, ld_n_s, clr_n_s, mid_s;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 6'h3C;
      sync2_ff <= 6'h3C;
    end else begin
      sync1_ff <= {preset_mid, clear_to_preset_n, load_strobe_n, chip_sel_n,
                   serial_in, serial_clk};
      sync2_ff <= sync1_ff;
    end
  end
  assign {mid_s, clr_n_s, ld_n_s, cs_n_s, sdi_s, sclk_s} = sync2_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b1;
    end else begin
      sclk_prev_ff <= sclk_s;
      cs_prev_ff <= cs_n_s;
    end
  end

  logic shift_en;
  logic cs_rise;
  assign shift_en = sclk_s && !sclk_prev_ff && !cs_n_s; // [RQ1] [RQ7]
  assign cs_rise = cs_n_s && !cs_prev_ff && !sclk_s; // [RQ5] [RQ9]

  // ==========================================================
  // Shift register
  // Width equals the word, so older surplus bits fall off the top
  logic [DDSL_WORD_W-1:0] shift_reg_ff;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_reg_ff <= '0;
    end else if (shift_en) begin
      shift_reg_ff <= {shift_reg_ff[DDSL_WORD_W-2:0], sdi_s}; // [RQ2] [RQ3] [RQ4] [RQ14]
    end
  end

  // ==========================================================
  // Word FIFO between select edge and input rank
  // A FIFO full of 16 words drops a new word, flagged only while clear is high; clear flushes it
  ddsl_word_t push_word;
  ddsl_word_t pop_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop_ready;

  assign push_word.sel = {shift_reg_ff[DDSL_ADDR_HI_POS], shift_reg_ff[DDSL_ADDR_LO_POS]};
  assign push_word.data = shift_reg_ff[DDSL_DATA_W-1:0];
  assign fifo_pop_ready = clr_n_s;

  ddsl_fifo #(
    .WIDTH($bits(ddsl_word_t)),
    .DEPTH(DDSL_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .flush(!clr_n_s), // [RQ18]
    .in_valid(cs_rise),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop_ready),
    .out_data(pop_word)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_dropped <= 1'b0;
    end else begin
      word_dropped <= cs_rise && !fifo_in_ready && clr_n_s;
    end
  end

  // ==========================================================
  // Register ranks
  logic [DDSL_DATA_W-1:0] preset_val;
  logic take_word;
  assign preset_val = mid_s ? DDSL_MID_VAL : DDSL_ZERO_VAL; // [RQ13] [RQ15]
  assign take_word = fifo_out_valid && fifo_pop_ready;

  function automatic logic hits_a(input logic [DDSL_ADDR_W-1:0] sel);
    hits_a = (sel == DDSL_SEL_A) || (sel == DDSL_SEL_BOTH);
  endfunction

  function automatic logic hits_b(input logic [DDSL_ADDR_W-1:0] sel);
    hits_b = (sel == DDSL_SEL_B) || (sel == DDSL_SEL_BOTH);
  endfunction

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_regs <= '0; // [RQ17]
    end else if (!clr_n_s) begin
      input_regs <= {preset_val, preset_val}; // [RQ13] [RQ18]
    end else if (take_word) begin
      if (hits_a(pop_word.sel)) begin
        input_regs.chan_a <= pop_word.data; // [RQ6]
      end
      if (hits_b(pop_word.sel)) begin
        input_regs.chan_b <= pop_word.data; // [RQ6]
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_regs <= '0; // [RQ17]
    end else if (!clr_n_s) begin
      conv_regs <= {preset_val, preset_val}; // [RQ13] [RQ18]
    end else if (!ld_n_s) begin
      conv_regs <= input_regs; // [RQ10] [RQ11] [RQ16]
    end
  end
endmodule

// ---- core/ddsl_pkg.sv ----
/*
  Shared constants and carrier types for the dual-channel serial loader.
  Assumes one 50 MHz core clock; the variant is picked by DDSL_DATA_W.
*/
package ddsl_pkg;
  // 16 for the wide variant, 14 for the narrow one
  localparam int DDSL_DATA_W = 16;
  localparam int DDSL_ADDR_W = 2;
  localparam int DDSL_WORD_W = DDSL_DATA_W + DDSL_ADDR_W;
  localparam int DDSL_ADDR_HI_POS = DDSL_WORD_W - 1;
  localparam int DDSL_ADDR_LO_POS = DDSL_WORD_W - 2;
  localparam logic [DDSL_DATA_W-1:0] DDSL_ZERO_VAL = 16'h0000;
  localparam logic [DDSL_DATA_W-1:0] DDSL_MID_VAL =
    (DDSL_DATA_W == 16) ? 16'h8000 : 16'h2000;
  localparam logic [DDSL_ADDR_W-1:0] DDSL_SEL_NONE = 2'h0;
  localparam logic [DDSL_ADDR_W-1:0] DDSL_SEL_A = 2'h1;
  localparam logic [DDSL_ADDR_W-1:0] DDSL_SEL_B = 2'h2;
  localparam logic [DDSL_ADDR_W-1:0] DDSL_SEL_BOTH = 2'h3;
  localparam int DDSL_FIFO_DEPTH = 16;
  localparam int DDSL_SYNC_STAGES = 2;

  typedef struct packed {
    logic [DDSL_ADDR_W-1:0] sel;
    logic [DDSL_DATA_W-1:0] data;
  } ddsl_word_t;

  typedef struct packed {
    logic [DDSL_DATA_W-1:0] chan_a;
    logic [DDSL_DATA_W-1:0] chan_b;
  } ddsl_pair_t;
endpackage

// ---- tb/ddsl_host_model.sv ----
/* Host on the three-wire port: sends frames of up to 24 bits, or clocks idly.
   Assumes a 50 MHz core_clk; serial clock period is 8 core cycles in a frame, 9 when clocking idly. */
`timescale 1ns/1ps
// ==========
// Host model
module ddsl_host_model (
  input wire logic core_clk,
  output logic serial_clk = 1'b0,
  output logic serial_in = 1'b0,
  output logic chip_sel_n = 1'b1
);
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  // Top six bits are byte padding the loader must drop
  task automatic send24(input logic [23:0] w, input int nbits);
    @(posedge core_clk);
    chip_sel_n <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in <= w[i];
      half();
      serial_clk <= 1'b1;
      half();
      serial_clk <= 1'b0;
    end
    half();
    chip_sel_n <= 1'b1;
    serial_in <= ~serial_in;
    half();
  endtask
  // Clock runs with select high; a loader that shifts here corrupts the next word
  task automatic clock_idle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      serial_in <= 1'b1;
      half();
      serial_clk <= 1'b1;
      half();
      serial_clk <= 1'b0;
    end
  endtask
endmodule

// ---- tb/ddsl_loader_sva.sv ----
/* Port checker for the serial loader.
   Assumes preset_mid stays steady while clear is held low. */
`timescale 1ns/1ps
// ==========
// Checker
module ddsl_loader_sva (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic chip_sel_n,
  input wire logic load_strobe_n,
  input wire logic clear_to_preset_n,
  input wire logic preset_mid,
  input wire ddsl_pkg::ddsl_pair_t input_regs,
  input wire ddsl_pkg::ddsl_pair_t conv_regs
);
  import ddsl_pkg::*;
  ddsl_pair_t pre;
  assign pre = preset_mid ? {2{DDSL_MID_VAL}} : '0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_reset_zero: assert property ($rose(reset_n) |->
    input_regs == 0 && conv_regs == 0) else $error("ranks not zero");
  a_clear_input: assert property (!clear_to_preset_n [*6] |-> input_regs == pre)
    else $error("input rank not preset");
  a_clear_conv: assert property (!clear_to_preset_n [*6] |-> conv_regs == pre)
    else $error("conv rank not preset");
  a_strobe_follow: assert property ((!load_strobe_n && clear_to_preset_n
    && $stable(input_regs)) [*6] |-> conv_regs == input_regs) else $error("conv not following");
  a_strobe_hold: assert property ((load_strobe_n && clear_to_preset_n) [*6]
    |=> $stable(conv_regs)) else $error("conv moved");
  a_desel_quiet: assert property ((chip_sel_n && clear_to_preset_n) [*8]
    |=> $stable(input_regs)) else $error("input moved");
  a_shift_quiet: assert property ((!chip_sel_n && clear_to_preset_n) [*8]
    |=> $stable(input_regs)) else $error("input moved in shift");
  a_conv_source: assert property ($changed(conv_regs) |-> conv_regs == pre
    || conv_regs == input_regs || conv_regs == $past(input_regs)) else $error("conv source");
endmodule
bind ddsl_loader ddsl_loader_sva chk (.core_clk, .reset_n, .chip_sel_n, .load_strobe_n,
  .clear_to_preset_n, .preset_mid, .input_regs, .conv_regs);

// ---- tb/tb_top.sv ----
/* Bench: host model on the serial pins, bench on strobe, clear, preset.
   Expected ranks are held in ei and ec. */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
// ==========
// Bench
module tb_top;
  import ddsl_pkg::*;
  logic core_clk, reset_n, serial_clk, serial_in, chip_sel_n;
  logic load_strobe_n, clear_to_preset_n, preset_mid;
  ddsl_pair_t input_regs, conv_regs, ei, ec;
  int fails, n_checks;
  logic word_dropped;
  int drops = 0;
  ddsl_host_model host (.core_clk, .serial_clk, .serial_in, .chip_sel_n);
  ddsl_loader dut (.core_clk, .reset_n, .serial_clk, .serial_in, .chip_sel_n, .load_strobe_n,
    .clear_to_preset_n, .preset_mid, .input_regs, .conv_regs, .word_dropped);
  // FIFO drains every cycle outside clear, so no word may ever be dropped
  always @(posedge core_clk) begin
    if (word_dropped === 1'b1) drops++;
  end
  task automatic summarize();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic settle();
    int i;
    for (i = 0; i < 40 && !(input_regs === ei && conv_regs === ec); i++) @(posedge core_clk);
    if (!(input_regs === ei && conv_regs === ec)) begin
      `CHK(input_regs, ei)
      `CHK(conv_regs, ec)
      summarize();
    end
  endtask
  task automatic put(logic [DDSL_ADDR_W-1:0] s, logic [DDSL_DATA_W-1:0] d);
    logic [23:0] w;
    w = 24'hFFFFFF;
    w[DDSL_WORD_W-1:0] = {s, d};
    host.send24(w, 24);
    if (clear_to_preset_n && s[0]) ei.chan_a = d;
    if (clear_to_preset_n && s[1]) ei.chan_b = d;
    if (!load_strobe_n) ec = ei;
    settle();
  endtask
  task automatic t_addr();
    for (int k = 0; k < 4; k++) begin
      put(k[1:0], DDSL_DATA_W'(24'h3C5A + k * 24'h0111));
      `CHK(input_regs, ei)
      `CHK(conv_regs, ec)
    end
  endtask
  task automatic t_sync();
    put(DDSL_SEL_A, DDSL_DATA_W'(24'h0F0F));
    put(DDSL_SEL_B, DDSL_DATA_W'(24'h00F0));
    `CHK(conv_regs, ec)
    load_strobe_n <= 1'b0;
    ec = ei;
    settle();
    `CHK(conv_regs, ec)
    load_strobe_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  // Short frame keeps the two low bits of the last word as its address
  task automatic t_partial();
    put(DDSL_SEL_A, DDSL_DATA_W'(24'h5A5A));
    host.clock_idle(6);
    host.send24(24'h00C3E1, 16);
    ei.chan_b = DDSL_DATA_W'(24'hC3E1);
    settle();
    `CHK(input_regs, ei)
    `CHK(conv_regs, ec)
  endtask
  task automatic t_clear();
    for (int m = 0; m < 2; m++) begin
      preset_mid <= m[0];
      clear_to_preset_n <= 1'b0;
      ei = m[0] ? {2{DDSL_MID_VAL}} : '0;
      ec = ei;
      put(DDSL_SEL_BOTH, DDSL_DATA_W'(24'h1357));
      `CHK(input_regs, ei)
      `CHK(conv_regs, ec)
      repeat (8) @(posedge core_clk);
      clear_to_preset_n <= 1'b1;
      load_strobe_n <= 1'b0;
      put(DDSL_SEL_BOTH, DDSL_DATA_W'(24'h2468));
      `CHK(conv_regs, ec)
      load_strobe_n <= 1'b1;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    reset_n = 1'b0;
    load_strobe_n = 1'b1;
    clear_to_preset_n = 1'b1;
    preset_mid = 1'b0;
    ei = '0;
    ec = '0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    t_addr();
    t_sync();
    t_partial();
    t_clear();
    `CHK(drops, 0)
    summarize();
  end
endmodule
